// >>> design/cts_pkg.sv
// Contract
// RL1 - poll every station in fixed repeating order
// RL2 - at most one transient between two stations
// RL3 - transients go only to data-capable stations
// RL4 - cyclic payload is exactly 32 bits
// RL5 - same station again only next cycle
// RL6 - transient carries up to 256 bytes
// RL7 - transients stretch cycle, none gives minimum
// RL8 - line level follows each sent bit
// RL9 - stuff bits bound constant line runs
// RL10 - header, start, address, payload, check, stop
// RL11 - address picks station, check code protects
// RL12 - no pending transient, go straight on
package cts_pkg;
  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int STN_MAX = 64;
  localparam int ADDR_W = 6;
  localparam int BYTE_W = 8;
  localparam int CYC_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam logic [7:0] HDR_LAST = 8'h07;
  localparam logic [7:0] ADDR_LAST = 8'h05;
  localparam logic [7:0] BYTE_LAST = 8'h07;
  localparam logic [7:0] CYC_LAST = 8'h1F;
  localparam logic [7:0] CHK_LAST = 8'h07;
  localparam logic [2:0] MAX_RUN = 3'h5;
  localparam logic [31:0] SH_RST = 32'h00000000;

  // ------------------------------------------------------------
  // scheduler states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_HDR = 4'h1,
    ST_START = 4'h2,
    ST_ADDR = 4'h3,
    ST_PAY = 4'h4,
    ST_CHK = 4'h5,
    ST_STOP = 4'h6,
    ST_GAP = 4'h7,
    ST_DROP = 4'h8
  } cts_st_t;

  typedef struct packed {
    cts_st_t st;
    logic [5:0] stn;
    logic [5:0] addr;
    logic trn;
    logic [31:0] sh;
    logic [7:0] chk;
    logic [7:0] bitn;
    logic [8:0] left;
    logic [2:0] run;
    logic last;
    logic pend;
    logic [5:0] paddr;
    logic [7:0] plen;
    logic txd;
    logic oe;
    logic load;
    logic cyc_end;
    logic drop_p;
    logic emt;
    logic [3:0] hc;
  } cts_q_t;
endpackage

// >>> design/cts_sched.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// byte fifo between the transient source and the serialiser
// ------------------------------------------------------------
module cts_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } cts_fifo_q_t;
  // an empty fifo accepts bytes, so ready resets high
  localparam cts_fifo_q_t FIFO_RST = '{
    mem: '0,
    wp: '0,
    rp: '0,
    cnt: '0,
    rdy: 1'b1
  };
  cts_fifo_q_t q, s;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction

  assign o_ready = q.rdy;
  assign o_valid = (q.cnt != '0);
  assign o_data = q.mem[q.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // empty comes straight from the occupancy count, full from a flop on the next count
  always_comb begin
    s = q;
    if (push) begin
      s.mem[q.wp] = i_data;
      s.wp = inc(q.wp);
    end
    if (pop) begin
      s.rp = inc(q.rp);
    end
    s.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // ready kept in a flop from the next count, so the pin is registered
    s.rdy = (s.cnt != (AW+1)'(D));
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= FIFO_RST;
    end else begin
      q <= s;
    end
  end
endmodule

// ------------------------------------------------------------
// cyclic / transient scheduler with nrz line and bit stuffing
// ------------------------------------------------------------
module cts_sched
  import cts_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic I_ENABLE,
  input wire logic [6:0] I_STN_COUNT,
  input wire logic [63:0] I_DATA_CAPABLE,
  input wire logic [31:0] I_CYC_DATA,
  input wire logic I_TRN_REQ,
  input wire logic [5:0] I_TRN_ADDR,
  input wire logic [7:0] I_TRN_LEN,
  input wire logic I_BYTE_VALID,
  input wire logic [7:0] I_BYTE_DATA,
  output logic O_BYTE_READY,
  output logic O_TRN_BUSY,
  output logic O_TRN_DROP,
  output logic [5:0] O_CYC_STN,
  output logic O_CYC_LOAD,
  output logic O_CYCLE_END,
  output logic O_TXD,
  output logic O_TXD_OE
);
  cts_q_t q, s;
  logic f_valid, f_pop, f_ready, emit, adv, bitv, start_trn, go_cyc;
  logic [7:0] f_data;

  // next station in the fixed order, wrapping at the count
  function automatic logic [5:0] nxt(input logic [5:0] st,
                                      input logic [6:0] cnt);
    nxt = ({1'b0, st} + 7'h01 >= cnt) ? 6'h00 : st + 6'h01;
  endfunction

  function automatic logic [7:0] xor4(input logic [31:0] w);
    xor4 = w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
  endfunction

  // fifo ready is registered inside the fifo, so it is a flop
  cts_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_valid(I_BYTE_VALID),
    .i_data(I_BYTE_DATA),
    .o_ready(f_ready),
    .o_valid(f_valid),
    .o_data(f_data),
    .i_ready(f_pop)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    s = q;
    s.load = 1'b0;
    s.cyc_end = 1'b0;
    s.drop_p = 1'b0;
    s.emt = 1'b0;
    f_pop = 1'b0;
    emit = 1'b0;
    adv = 1'b0;
    bitv = 1'b0;
    start_trn = 1'b0;
    go_cyc = 1'b0;
    // one transient held at a time; busy shows it
    if (!q.pend && I_TRN_REQ) begin
      s.pend = 1'b1;
      s.paddr = I_TRN_ADDR;
      s.plen = I_TRN_LEN; // length minus one, so 256 fits RL6
    end
    case (q.st)
      ST_IDLE: begin
        s.oe = 1'b0;
        go_cyc = I_ENABLE && (I_STN_COUNT != 7'h00);
      end
      ST_HDR: begin
        bitv = q.bitn[0]; // alternating ones and zeros RL10
        emit = 1'b1;
      end
      ST_START: emit = 1'b1;
      ST_ADDR: begin
        bitv = q.addr[q.bitn[2:0]]; // target station RL11
        emit = 1'b1;
      end
      ST_PAY: begin
        bitv = q.sh[31];
        // an empty fifo mid-frame holds the line: source must keep up
        emit = !(q.trn && q.bitn == 8'h00 && q.left != 9'h000 &&
                 !f_valid && q.run != MAX_RUN);
      end
      ST_CHK: begin
        bitv = q.chk[q.bitn[2:0]]; // check code ahead of the closing stop bit RL11
        emit = 1'b1;
      end
      ST_STOP: begin
        bitv = 1'b1;
        emit = 1'b1;
      end
      ST_GAP: begin
        s.oe = 1'b0;
        if (q.pend && !q.trn && !I_DATA_CAPABLE[q.paddr]) begin
          s.st = ST_DROP; // plain i/o stations take no transient RL3
          s.left = {1'b0, q.plen} + 9'h001;
          s.drop_p = 1'b1;
        end else if (q.pend && !q.trn && f_valid) begin
          start_trn = 1'b1; // only after a cyclic frame RL2
        end else begin
          go_cyc = I_ENABLE && (I_STN_COUNT != 7'h00); // RL12 RL7
          if (!go_cyc) begin
            s.st = ST_IDLE;
          end
        end
      end
      ST_DROP: begin
        // discard the refused bytes so the fifo stays aligned
        if (f_valid) begin
          f_pop = 1'b1;
          s.left = q.left - 9'h001;
          if (q.left == 9'h001) begin
            s.st = ST_GAP;
            s.trn = 1'b1;
            s.pend = 1'b0;
          end
        end
      end
      default: s.st = ST_IDLE;
    endcase

    // nrz line with a forced flip after MAX_RUN equal bits
    if (emit) begin
      s.oe = 1'b1;
      s.emt = 1'b1;
      if (q.run == MAX_RUN) begin
        s.txd = ~q.last; // RL9
        s.last = ~q.last;
        s.run = 3'h1;
      end else begin
        s.txd = bitv; // RL8
        s.last = bitv;
        s.run = (bitv == q.last) ? q.run + 3'h1 : 3'h1;
        adv = 1'b1;
      end
    end

    // field sequencing RL10
    if (adv) begin
      s.bitn = q.bitn - 8'h01;
      case (q.st)
        ST_HDR: begin
          if (q.bitn == 8'h00) begin
            s.st = ST_START;
          end
        end
        ST_START: begin
          s.st = ST_ADDR;
          s.bitn = ADDR_LAST;
        end
        ST_ADDR: begin
          if (q.bitn == 8'h00) begin
            s.st = ST_PAY;
            s.bitn = q.trn ? BYTE_LAST : CYC_LAST; // RL4 RL6
          end
        end
        ST_PAY: begin
          s.sh = {q.sh[30:0], 1'b0};
          if (q.bitn == 8'h00) begin
            if (q.trn && q.left != 9'h000) begin
              f_pop = 1'b1;
              s.sh = {f_data, 24'h000000};
              s.chk = q.chk ^ f_data;
              s.left = q.left - 9'h001;
              s.bitn = BYTE_LAST;
            end else begin
              s.st = ST_CHK;
              s.bitn = CHK_LAST;
            end
          end
        end
        ST_CHK: begin
          if (q.bitn == 8'h00) begin
            s.st = ST_STOP;
          end
        end
        ST_STOP: s.st = ST_GAP;
        default: s.st = ST_IDLE;
      endcase
    end

    // frame starts: both restart the run counter and header
    if (go_cyc) begin
      s.st = ST_HDR;
      s.bitn = HDR_LAST;
      s.run = 3'h0;
      s.trn = 1'b0;
      s.addr = q.stn; // fixed order, one station per slot RL1
      s.sh = I_CYC_DATA; // full 32-bit payload RL4
      s.chk = xor4(I_CYC_DATA);
      s.load = 1'b1;
      s.stn = nxt(q.stn, I_STN_COUNT); // back only after a lap RL5
      s.cyc_end = (nxt(q.stn, I_STN_COUNT) == 6'h00);
    end
    if (start_trn) begin
      s.st = ST_HDR;
      s.bitn = HDR_LAST;
      s.run = 3'h0;
      s.trn = 1'b1;
      s.addr = q.paddr;
      f_pop = 1'b1;
      s.sh = {f_data, 24'h000000};
      s.chk = f_data;
      s.left = {1'b0, q.plen};
      s.pend = 1'b0;
    end

    // check helper: consecutive equal emitted bits
    s.hc = (s.emt && q.emt && s.txd == q.txd) ? q.hc + 4'h1 : 4'h1;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------
  assign O_BYTE_READY = f_ready;
  assign O_TRN_BUSY = q.pend;
  assign O_TRN_DROP = q.drop_p;
  assign O_CYC_STN = q.stn;
  assign O_CYC_LOAD = q.load;
  assign O_CYCLE_END = q.cyc_end;
  assign O_TXD = q.txd;
  assign O_TXD_OE = q.oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_ARST_N);

  run_bound_a: assert property (q.hc <= {1'b0, MAX_RUN}) // RL9
    else $error("line held constant too long");
  hdr_toggle_a: assert property ( // RL10
    (q.st == ST_HDR && $past(q.st) == ST_HDR) |=>
      (O_TXD != $past(O_TXD)))
    else $error("header not alternating");
  start_low_a: assert property ((q.st == ST_START) |=> !O_TXD) // RL10
    else $error("start bit not low");
  stop_high_a: assert property ( // RL10
    (q.st == ST_STOP && q.run != MAX_RUN) |=> (O_TXD && O_TXD_OE))
    else $error("stop bit not high");
  one_trn_a: assert property (start_trn |-> !q.trn) // RL2
    else $error("two transients in one gap");
  cyc_width_a: assert property ( // RL4
    (q.st == ST_ADDR && s.st == ST_PAY && !q.trn) |=>
      (q.bitn == 8'h1F))
    else $error("cyclic payload not 32 bits");
  stn_order_a: assert property ( // RL1
    O_CYC_LOAD |-> (O_CYC_STN == nxt(q.addr, I_STN_COUNT)))
    else $error("station order broken");
  drop_plain_a: assert property ( // RL3
    (q.st == ST_GAP && q.pend && !q.trn &&
     !I_DATA_CAPABLE[q.paddr]) |=> (q.st == ST_DROP && O_TRN_DROP))
    else $error("transient sent to plain station");
  direct_cyc_a: assert property ( // RL12
    (q.st == ST_GAP && !q.pend && I_ENABLE &&
     I_STN_COUNT != 7'h00) |=> (q.st == ST_HDR && O_CYC_LOAD))
    else $error("idle slot did not move on");
endmodule

// >>> verif/cts_stn_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// local station model: destuffs and decodes each line frame
// ------------------------------------------------------------
module cts_stn_model (
  input wire logic i_clk,
  input wire logic i_txd,
  input wire logic i_oe,
  output logic o_done,
  output logic [5:0] o_addr,
  output int o_len,
  output logic [31:0] o_word,
  output logic o_ok
);
  logic q[$];
  logic prv, oe_q, ok;
  logic [7:0] x, c;
  logic [5:0] a;
  logic [31:0] w;
  int run, n, p;
  initial oe_q = 1'b0;
  initial o_done = 1'b0;
  // one bit a clock while driven; decode once the line is let go
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_oe) begin
      if (!oe_q) begin
        q = {};
        run = 0;
        ok = 1'b1;
      end
      if (run == 5) begin
        ok &= (i_txd != prv);
        run = 1;
      end else begin
        run = (run > 0 && i_txd == prv) ? run + 1 : 1;
        q.push_back(i_txd);
      end
      prv = i_txd;
    end else if (oe_q) begin
      n = q.size();
      p = n - 24;
      w = '0;
      x = '0;
      c = '0;
      a = '0;
      // short or ragged frames are flagged, never indexed
      if (p < 8 || p % 8 != 0) begin
        ok = 1'b0;
      end else begin
        for (int i = 0; i < 8; i++) begin
          ok &= (q[i] == !i[0]);
          c = {c[6:0], q[n - 9 + i]};
        end
        for (int i = 0; i < 6; i++) a = {a[4:0], q[9 + i]};
        for (int i = 0; i < p; i++) begin
          w = {w[30:0], q[15 + i]};
          if (i % 8 == 7) x ^= w[7:0];
        end
        ok &= (q[8] == 1'b0) && (q[n - 1] == 1'b1);
        ok &= (x == c);
      end
      o_done <= 1'b1;
      o_addr <= a;
      o_len <= p;
      o_word <= w;
      o_ok <= ok;
    end
    oe_q = i_oe;
  end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int NS = 4;
  logic clk, rst_n, req, bvld, busy, drop, load, cend, txd, oe, brdy;
  logic done, ok, saw_full, had, ptrn;
  logic [31:0] cyc, word;
  logic [31:0] tbl [NS];
  logic [5:0] taddr, faddr, cstn;
  logic [7:0] tlen, bdat;
  logic [15:0] seed;
  logic [7:0] bq[$], tq[$];
  logic [5:0] ea[$];
  logic [31:0] ew[$];
  int el[$];
  int flen, bad_count, num_checks, exp_stn, tcnt, last, base;

  cts_sched dut (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_ENABLE(1'b1),
    .I_STN_COUNT(7'h04), .I_DATA_CAPABLE(64'h0000000000000007),
    .I_CYC_DATA(cyc), .I_TRN_REQ(req), .I_TRN_ADDR(taddr),
    .I_TRN_LEN(tlen), .I_BYTE_VALID(bvld), .I_BYTE_DATA(bdat),
    .O_BYTE_READY(brdy), .O_TRN_BUSY(busy), .O_TRN_DROP(drop),
    .O_CYC_STN(cstn), .O_CYC_LOAD(load), .O_CYCLE_END(cend),
    .O_TXD(txd), .O_TXD_OE(oe));
  cts_stn_model stn (.i_clk(clk), .i_txd(txd), .i_oe(oe), .o_done(done),
    .o_addr(faddr), .o_len(flen), .o_word(word), .o_ok(ok));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wcend();
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk);
      if (cend) break;
    end
  endtask

  // ------------------------------------------------------------
  // transient request: bytes are staged, hold keeps them back
  // ------------------------------------------------------------
  task automatic trn(input logic [5:0] a, input int l, input logic hold,
                     input logic good);
    logic [31:0] w;
    w = '0;
    tq = {};
    for (int i = 0; i <= l; i++) begin
      seed = lfsr(seed);
      tq.push_back(seed[7:0]);
      w = {w[23:0], seed[7:0]};
    end
    if (good) begin
      ea.push_back(a);
      el.push_back(8 * (l + 1));
      ew.push_back(w);
    end
    if (!hold) bq = {bq, tq};
    @(posedge clk);
    while (busy) @(posedge clk);
    #1;
    req = 1'b1;
    taddr = a;
    tlen = l[7:0];
    @(posedge clk);
    #1;
    req = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // byte feeder: data held until the fifo takes it
  always @(posedge clk) begin
    if (bvld && brdy) void'(bq.pop_front());
    if (!brdy) saw_full = 1'b1;
    #1;
    bvld = bq.size() > 0;
    if (bvld) bdat = bq[0];
  end

  always @(posedge clk) begin
    #1;
    cyc = tbl[cstn[1:0]];
  end

  // ------------------------------------------------------------
  // frame and cycle monitor; frames first so a transient counts
  // ------------------------------------------------------------
  always @(posedge clk) begin
    tcnt++;
    if (drop) had = 1'b1;
    if (done) begin
      chk("frame_ok", ok, 1'b1);
      if (flen == 32) begin
        chk("cyc_stn", faddr, exp_stn);
        chk("cyc_word", word, tbl[faddr[1:0]]);
        exp_stn = (exp_stn + 1) % NS;
        ptrn = 1'b0;
      end else if (ea.size() == 0) begin
        chk("trn_extra", 1'b1, 1'b0);
      end else begin
        chk("trn_pair", ptrn, 1'b0);
        chk("trn_cap", faddr < 6'h03, 1'b1);
        chk("trn_addr", faddr, ea.pop_front());
        chk("trn_len", flen, el.pop_front());
        chk("trn_word", word, ew.pop_front());
        ptrn = 1'b1;
        had = 1'b1;
      end
    end
    if (cend) begin
      if (last > 0 && base == 0) base = tcnt - last;
      else if (last > 0 && had) chk("cyc_long", tcnt - last > base, 1);
      else if (last > 0) chk("cyc_len", tcnt - last, base);
      had = 1'b0;
      last = tcnt;
    end
  end

  initial begin
    #(50 * 90000);
    bad_count++;
    test_done();
  end

  initial begin
    {rst_n, req, bvld, saw_full, had, ptrn} = '0;
    {taddr, tlen, bdat, cyc} = '0;
    {bad_count, num_checks, exp_stn, tcnt, last, base} = '0;
    seed = 16'h000B;
    for (int i = 0; i < NS; i++) begin
      seed = lfsr(seed);
      tbl[i] = {seed, lfsr(seed)};
    end
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) wcend();
    trn(6'h00, 0, 1'b0, 1'b1);
    trn(6'h02, 255, 1'b0, 1'b1);
    repeat (2) begin
      seed = lfsr(seed);
      trn({4'h0, seed[1:0] % 2'h3}, {24'h0, seed[11:4] | 8'h04}, 1'b0, 1'b1);
    end
    // refused target: drop pulse, its bytes drained unsent
    trn(6'h03, 5, 1'b0, 1'b0);
    for (int i = 0; i < 20000 && !drop; i++) @(posedge clk);
    chk("drop", drop, 1'b1);
    // pending request with an empty fifo must not stall cycles
    trn(6'h01, 1, 1'b1, 1'b1);
    repeat (2) wcend();
    chk("trn_wait", busy, 1'b1);
    bq = {bq, tq};
    for (int i = 0; i < 30000 && ea.size() > 0; i++) @(posedge clk);
    repeat (2) wcend();
    chk("trn_sent", ea.size(), 0);
    chk("fifo_full", saw_full, 1'b1);
    test_done();
  end
endmodule
